//--- include/dual_slope_cfg.svh
`ifndef DUAL_SLOPE_CFG_SVH
`define DUAL_SLOPE_CFG_SVH

// ----------------------------------------
// Phase select codes, high bit then low bit
// ----------------------------------------
`define PH_CODE_OFFSET_NULL 2'h1
`define PH_CODE_INTEGRATE 2'h2
`define PH_CODE_REF_RAMP 2'h3
`define PH_CODE_OUT_ZERO 2'h0

// ----------------------------------------
// Timing, in nanoseconds and in clock cycles at 50 MHz
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define OFFSET_NULL_NS 1000000
`define OFFSET_NULL_CYC (`OFFSET_NULL_NS / `CLK_PERIOD_NS)
`define INTEGRATE_NS 33000000
`define INTEGRATE_CYC (`INTEGRATE_NS / `CLK_PERIOD_NS)
`define REF_RAMP_MAX_CYC (2 * `INTEGRATE_CYC)
`define OUT_ZERO_MAX_CYC (`OFFSET_NULL_CYC)
// Comparator readings that still predate the present phase (two sync flops)
`define CMP_SYNC_CYC 2
`define CNT_W 32

`endif

//--- include/dual_slope_pkg.sv
package dual_slope_pkg;

    // Conversion phases in their fixed running order
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OFFSET_NULL,
        ST_INTEGRATE,
        ST_REF_RAMP,
        ST_OUT_ZERO
    } phase_e;

    // Pins that go to the converter
    typedef struct packed {
        logic phase_hi;
        logic phase_lo;
        logic chan_sel_hi;
        logic chan_sel_lo;
    } dev_pins_s;

    // One finished measurement
    typedef struct packed {
        logic negative;
        logic overrange;
        logic [31:0] ramp_count;
    } result_s;

endpackage : dual_slope_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-stage synchroniser for one pin
// ----------------------------------------
module pin_sync (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin_in,
    output logic pin_sync_out
);

    logic meta_reg; // First stage, read only by the second
    logic meta_next;
    logic sync_reg; // Second stage, safe to use
    logic sync_next;

    // Next values
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    // Registers; reset level high matches comparator idle after zeroing
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_reg <= 1'h1;
            sync_reg <= 1'h1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pin_sync_out = sync_reg;

endmodule : pin_sync

`default_nettype wire

//--- rtl/dual_slope_phase_sequencer.sv
// Contract
// - Run null, integrate, ramp, zero in order
// - Integration period fixed every conversion
// - Ramp follows integration with no gap
// - Time ramp until comparator falls
// - Magnitude is reference times time ratio
// - Integrator zeroed before each integration
// - Zero until comparator high; ignore during null
// - Store comparator at integration end
`timescale 1ns/1ps
`default_nettype none
`include "dual_slope_cfg.svh"

module dual_slope_phase_sequencer #(
    parameter int unsigned OFFSET_NULL_CYC = `OFFSET_NULL_CYC,
    parameter int unsigned INTEGRATE_CYC = `INTEGRATE_CYC,
    parameter int unsigned REF_RAMP_MAX_CYC = `REF_RAMP_MAX_CYC,
    parameter int unsigned OUT_ZERO_MAX_CYC = `OUT_ZERO_MAX_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    input wire logic [1:0] channel,
    input wire logic zero_cross_out,
    output logic busy,
    output logic done,
    output dual_slope_pkg::result_s result,
    output dual_slope_pkg::dev_pins_s dev_pins
);

    // ----------------------------------------
    // Comparator pin synchroniser
    // ----------------------------------------
    logic cmp_sync; // Comparator after two flops

    pin_sync u_cmp_sync (
        .mclk(mclk),
        .reset(reset),
        .pin_in(zero_cross_out),
        .pin_sync_out(cmp_sync)
    );

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    dual_slope_pkg::phase_e state_reg; // Current phase
    dual_slope_pkg::phase_e state_next;
    logic [`CNT_W-1:0] cnt_reg; // Cycles spent in the phase
    logic [`CNT_W-1:0] cnt_next;
    logic cmp_prev_reg; // Comparator one cycle ago, for edge detect
    logic cmp_prev_next;
    logic polarity_neg_reg; // Latched input sign
    logic polarity_neg_next;
    logic [1:0] chan_reg; // Channel held for the whole conversion
    logic [1:0] chan_next;
    logic [1:0] code_reg; // Phase code on the pins
    logic [1:0] code_next;
    logic done_reg;
    logic done_next;
    dual_slope_pkg::result_s result_reg;
    dual_slope_pkg::result_s result_next;
    logic cmp_fall; // Comparator high-to-low seen

    assign cmp_fall = cmp_prev_reg & ~cmp_sync;

    // Next-state logic for the whole conversion
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + `CNT_W'h1;
        cmp_prev_next = cmp_sync;
        polarity_neg_next = polarity_neg_reg;
        chan_next = chan_reg;
        code_next = code_reg;
        done_next = 1'h0;
        result_next = result_reg;
        unique case (state_reg)
            dual_slope_pkg::ST_IDLE: begin
                cnt_next = '0;
                // Idle parks in zeroing so the integrator stays at 0 V
                code_next = `PH_CODE_OUT_ZERO;
                if (start) begin
                    state_next = dual_slope_pkg::ST_OFFSET_NULL;
                    chan_next = channel;
                    code_next = `PH_CODE_OFFSET_NULL;
                end
            end
            dual_slope_pkg::ST_OFFSET_NULL: begin
                // Comparator is meaningless here, so it is not looked at
                if (cnt_reg >= `CNT_W'(OFFSET_NULL_CYC - 1)) begin
                    state_next = dual_slope_pkg::ST_INTEGRATE;
                    code_next = `PH_CODE_INTEGRATE;
                    cnt_next = '0;
                end
            end
            dual_slope_pkg::ST_INTEGRATE: begin
                // Fixed length every time
                if (cnt_reg >= `CNT_W'(INTEGRATE_CYC - 1)) begin
                    polarity_neg_next = ~cmp_sync; // Sign read at the end only
                    state_next = dual_slope_pkg::ST_REF_RAMP; // No gap
                    code_next = `PH_CODE_REF_RAMP;
                    cnt_next = '0; // Precision timer starts
                end
            end
            dual_slope_pkg::ST_REF_RAMP: begin
                // Timer runs until the zero crossing; a cap stops a stuck ramp
                if (cmp_fall || cnt_reg >= `CNT_W'(REF_RAMP_MAX_CYC - 1)) begin
                    // Count relative to the integration count gives V = Vref*T/Tint
                    result_next.ramp_count = cnt_reg;
                    result_next.negative = polarity_neg_reg;
                    result_next.overrange = ~cmp_fall;
                    state_next = dual_slope_pkg::ST_OUT_ZERO;
                    code_next = `PH_CODE_OUT_ZERO;
                    cnt_next = '0;
                end
            end
            dual_slope_pkg::ST_OUT_ZERO: begin
                // Wait for comparator high, bounded in case it never returns
                // The first readings still carry the ramp's level through the flops;
                // after a capped ramp that level is high, so it must not end zeroing
                if ((cmp_sync && cnt_reg >= `CNT_W'(`CMP_SYNC_CYC))
                    || cnt_reg >= `CNT_W'(OUT_ZERO_MAX_CYC - 1)) begin
                    state_next = dual_slope_pkg::ST_IDLE;
                    done_next = 1'h1;
                    cnt_next = '0;
                end
            end
        endcase
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= dual_slope_pkg::ST_IDLE;
            cnt_reg <= '0;
            cmp_prev_reg <= 1'h1;
            polarity_neg_reg <= 1'h0;
            chan_reg <= 2'h0;
            code_reg <= `PH_CODE_OUT_ZERO;
            done_reg <= 1'h0;
            result_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cmp_prev_reg <= cmp_prev_next;
            polarity_neg_reg <= polarity_neg_next;
            chan_reg <= chan_next;
            code_reg <= code_next;
            done_reg <= done_next;
            result_reg <= result_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Both phase bits come from one register, so they switch on the same edge
    assign dev_pins.phase_hi = code_reg[1];
    assign dev_pins.phase_lo = code_reg[0];
    assign dev_pins.chan_sel_hi = chan_reg[1];
    assign dev_pins.chan_sel_lo = chan_reg[0];
    assign busy = (state_reg != dual_slope_pkg::ST_IDLE);
    assign done = done_reg;
    assign result = result_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_int_end;
        state_reg == dual_slope_pkg::ST_INTEGRATE && state_next == dual_slope_pkg::ST_REF_RAMP;
    endsequence

    a_phase_order: assert property (@(posedge mclk) disable iff (reset)
        $changed(state_reg) && state_reg == dual_slope_pkg::ST_INTEGRATE
        |-> $past(state_reg) == dual_slope_pkg::ST_OFFSET_NULL)
        else $error("Integration not preceded by offset null");

    a_code_match: assert property (@(posedge mclk) disable iff (reset)
        state_reg == dual_slope_pkg::ST_REF_RAMP |-> code_reg == `PH_CODE_REF_RAMP)
        else $error("Ramp phase code wrong");

    a_int_fixed: assert property (@(posedge mclk) disable iff (reset)
        s_int_end |-> cnt_reg == `CNT_W'(INTEGRATE_CYC - 1))
        else $error("Integration length not fixed");

    a_ramp_follows: assert property (@(posedge mclk) disable iff (reset)
        s_int_end |=> state_reg == dual_slope_pkg::ST_REF_RAMP && code_reg == `PH_CODE_REF_RAMP)
        else $error("Ramp did not follow integration");

    a_sign_latch: assert property (@(posedge mclk) disable iff (reset)
        s_int_end |=> polarity_neg_reg == ~$past(cmp_sync))
        else $error("Polarity not latched at integration end");

    a_ramp_stop: assert property (@(posedge mclk) disable iff (reset)
        state_reg == dual_slope_pkg::ST_REF_RAMP && cmp_fall
        |=> state_reg == dual_slope_pkg::ST_OUT_ZERO && result_reg.ramp_count == $past(cnt_reg))
        else $error("Ramp did not stop at comparator fall");

    a_zero_first: assert property (@(posedge mclk) disable iff (reset)
        state_reg == dual_slope_pkg::ST_OFFSET_NULL && $past(state_reg) == dual_slope_pkg::ST_IDLE
        |-> $past(code_reg) == `PH_CODE_OUT_ZERO)
        else $error("Integrator not zeroed before null");

    a_zero_exit: assert property (@(posedge mclk) disable iff (reset)
        state_reg == dual_slope_pkg::ST_OUT_ZERO && cmp_sync
        && cnt_reg >= `CNT_W'(`CMP_SYNC_CYC) |=> done_reg)
        else $error("Zeroing did not end on comparator high");

    a_zero_fresh: assert property (@(posedge mclk) disable iff (reset)
        state_reg == dual_slope_pkg::ST_OUT_ZERO && cnt_reg < `CNT_W'(`CMP_SYNC_CYC)
        |=> state_reg == dual_slope_pkg::ST_OUT_ZERO)
        else $error("Zeroing ended on a stale comparator level");

    a_chan_hold: assert property (@(posedge mclk) disable iff (reset)
        busy && $past(busy) |-> $stable(chan_reg))
        else $error("Channel changed mid conversion");

endmodule : dual_slope_phase_sequencer

`default_nettype wire

//--- tb/converter_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Behavioural converter front end
// ----------------------------------------
module converter_model (
    input wire logic mclk,
    input wire dual_slope_pkg::dev_pins_s dev_pins,
    input wire logic [3:0][15:0] vin_set,
    input wire logic [15:0] vref,
    output logic zero_cross_out
);
    logic [1:0] code; // Phase lines as seen now
    logic [1:0] pair; // Selected input pair
    int acc = 0; // Integrator level in input units
    logic pos_reg = 1'b1; // Sign of the integrated input
    logic tgl_reg = 1'b0; // Junk level while nulling
    int zero_cnt = 0; // Cycles spent in zeroing

    assign code = {dev_pins.phase_hi, dev_pins.phase_lo};
    assign pair = {dev_pins.chan_sel_hi, dev_pins.chan_sel_lo};

    // Integrator moves with the switch pattern of the present code
    always @(posedge mclk) begin
        tgl_reg <= ~tgl_reg;
        zero_cnt <= (code == 2'h0) ? zero_cnt + 1 : 0;
        case (code)
            2'h2: begin // Only the input switches closed
                acc <= acc + int'($signed(vin_set[pair]));
                pos_reg <= (acc + int'($signed(vin_set[pair]))) >= 0;
            end
            2'h3: acc <= pos_reg ? acc - int'(vref) : acc + int'(vref);
            default: acc <= 0; // Null loop and zeroing settle at 0 V
        endcase
    end

    // Comparator; slow to come back high so zeroing must wait for it
    always_comb begin
        case (code)
            2'h1: zero_cross_out = tgl_reg; // Undefined while nulling
            2'h2: zero_cross_out = acc > 0; // High for a positive input
            2'h3: zero_cross_out = pos_reg ? acc > 0 : acc < 0; // Falls at the crossing
            default: zero_cross_out = zero_cnt >= 3; // Recovers late
        endcase
    end
endmodule : converter_model
`default_nettype wire

//--- tb/dual_slope_phase_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none

module dual_slope_phase_sequencer_test;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic mclk = 1'b0;
    logic reset = 1'b1; // Held for the first six cycles
    logic start = 1'b0;
    logic [1:0] channel = 2'h0;
    logic [3:0][15:0] vin_set = {16'h2, 16'hfffa, 16'h5, 16'h3}; // Pair 3 down to 0
    logic [15:0] vref = 16'h4;
    logic zero_cross_out;
    logic busy;
    logic done;
    dual_slope_pkg::result_s result;
    dual_slope_pkg::dev_pins_s dev_pins;
    int error_cnt = 0;
    int samples_checked = 0;

    always #10 mclk = ~mclk; // 50 MHz

    // Short counts keep the run brief; expectations follow from them
    dual_slope_phase_sequencer #(.OFFSET_NULL_CYC(8), .INTEGRATE_CYC(16),
        .REF_RAMP_MAX_CYC(40), .OUT_ZERO_MAX_CYC(20)) dut (.mclk(mclk), .reset(reset),
        .start(start), .channel(channel), .zero_cross_out(zero_cross_out), .busy(busy),
        .done(done), .result(result), .dev_pins(dev_pins));

    converter_model far_end (.mclk(mclk), .dev_pins(dev_pins), .vin_set(vin_set),
        .vref(vref), .zero_cross_out(zero_cross_out));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic finish_test();
        $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk_num(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : chk_num

    // Ramp timing carries synchroniser latency, so a window is judged
    task automatic chk_range(input string name, input logic [31:0] lo, input logic [31:0] hi,
        input logic [31:0] got);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("wrong value %s: expected %0h..%0h, seen %0h", name, lo, hi, got);
        end
    endtask : chk_range

    // ----------------------------------------
    // One conversion, judged on order, lengths and result
    // ----------------------------------------
    task automatic run_conv(input logic [1:0] ch, input logic [15:0] vr, input logic exp_neg,
        input logic exp_ovr, input logic [31:0] exp_cnt);
        logic [1:0] seq[$];
        logic [1:0] code;
        int len[4];
        int n;
        vref = vr;
        start = 1'b1;
        channel = ch;
        @(negedge mclk);
        start = 1'b0;
        channel = ~ch; // Must be ignored while busy
        len = '{default: 0};
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            code = {dev_pins.phase_hi, dev_pins.phase_lo};
            if (seq.size() == 0 || seq[$] !== code) begin
                seq.push_back(code);
            end
            len[code]++;
            n++;
            start = (n == 20); // Second request while busy
            if (n == 20) begin
                chk_num("busy", 32'h1, 32'(busy));
            end
            @(negedge mclk);
        end
        start = 1'b0;
        if (n >= 400) begin
            error_cnt++;
            finish_test();
        end
        chk_num("order", 32'h1230, 32'({2'h0, seq[0], 2'h0, seq[1], 2'h0, seq[2], 2'h0, seq[3]}));
        chk_num("null len", 32'h8, len[1]);
        chk_num("integrate len", 32'h10, len[2]);
        chk_range("zero len", 32'h4, 32'h15, len[0]);
        chk_num("channel", 32'(ch), 32'({dev_pins.chan_sel_hi, dev_pins.chan_sel_lo}));
        chk_num("negative", 32'(exp_neg), 32'(result.negative));
        chk_num("overrange", 32'(exp_ovr), 32'(result.overrange));
        if (!exp_ovr) begin
            chk_range("ramp count", exp_cnt, exp_cnt + 32'h4, result.ramp_count);
        end
        @(negedge mclk);
        chk_num("done pulse", 32'h0, 32'(done));
        chk_num("no restart", 32'h0, 32'(busy));
    endtask : run_conv

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic all_channels();
        run_conv(2'h0, 16'h4, 1'b0, 1'b0, 32'hc);
        run_conv(2'h1, 16'h4, 1'b0, 1'b0, 32'h14);
        run_conv(2'h2, 16'h4, 1'b1, 1'b0, 32'h18);
        run_conv(2'h3, 16'h2, 1'b0, 1'b0, 32'h10);
    endtask : all_channels

    // Ramp cannot reach zero before the cap
    task automatic overrange();
        vin_set[1] = 16'h8;
        run_conv(2'h1, 16'h1, 1'b0, 1'b1, 32'h0);
    endtask : overrange

    // Reset in mid integration, then a clean restart
    task automatic reset_mid();
        start = 1'b1;
        channel = 2'h3;
        @(negedge mclk);
        start = 1'b0;
        repeat (12) @(negedge mclk);
        reset = 1'b1;
        @(negedge mclk);
        chk_num("reset busy", 32'h0, 32'(busy));
        chk_num("reset pins", 32'h0, 32'(dev_pins));
        chk_num("reset count", 32'h0, result.ramp_count);
        reset = 1'b0;
        run_conv(2'h0, 16'h4, 1'b0, 1'b0, 32'hc);
    endtask : reset_mid

    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        all_channels();
        overrange();
        reset_mid();
        finish_test();
    end
endmodule : dual_slope_phase_sequencer_test
`default_nettype wire
